//--- pptl_defines.svh
// Constants of the pulse-train position loop: offsets, fields, resets, timing.
// Assumes a 50 MHz pclk and an APB register bus with 32-bit data.
// Notes on behaviour
// - Speed command drives command-feedback difference to zero
// - Command pulses geared, accumulated into deflection counter
// - Encoder feedback pulses subtracted from deflection counter
// - No pulses: counter empties, motor stops
// - Travel follows pulse count, speed follows frequency
// - Servo-on releases base, ready after 0.1 s
// - Servo-on released blocks the base drive
// - Direction allowed only while its stroke input closed
// - Setting 0 to 5 selects command pulse format
// - Gear settings 0..32767, default 1, ratio 1/50..20
// - Gear setting of zero is treated as one
// - Clear input falling edge resets deflection counter
// - Done output gives positioning complete in position mode
`ifndef PPTL_DEFINES_SVH
`define PPTL_DEFINES_SVH

`define PPTL_CLK_MHZ         50
`define PPTL_READY_DELAY_US  100000

`define PPTL_NSYNC           8
`define PPTL_IN_FWD_PULSE    0
`define PPTL_IN_REV_PULSE    1
`define PPTL_IN_SERVO_ON     2
`define PPTL_IN_FWD_STROKE   3
`define PPTL_IN_REV_STROKE   4
`define PPTL_IN_CLEAR        5
`define PPTL_IN_ENC_A        6
`define PPTL_IN_ENC_B        7

`define PPTL_ADDR_W          8
`define PPTL_OFS_CTRL        8'h00
`define PPTL_OFS_GEAR_NUM    8'h04
`define PPTL_OFS_GEAR_DEN    8'h08
`define PPTL_OFS_DONE_WIDTH  8'h0C
`define PPTL_OFS_STATUS      8'h10
`define PPTL_OFS_DEFL        8'h14
`define PPTL_OFS_SPEED       8'h18
`define PPTL_OFS_INT_STAT    8'h1C
`define PPTL_OFS_INT_EN      8'h20
`define PPTL_OFS_INT_CLR     8'h24

`define PPTL_SET_W           15
`define PPTL_FMT_W           3
`define PPTL_FMT_DEF         3'h0
`define PPTL_FMT_MAX         3'h5
`define PPTL_GEAR_DEF        15'h0001
`define PPTL_DONE_WIDTH_DEF  15'h0064
`define PPTL_GEAR_MAX_MUL    22'h000014
`define PPTL_GEAR_MIN_DIV    22'h000032

`define PPTL_NINT            4
`define PPTL_INT_READY       0
`define PPTL_INT_DONE        1
`define PPTL_INT_CLEAR       2
`define PPTL_INT_STROKE      3

`define PPTL_ST_BASE         0
`define PPTL_ST_READY        1
`define PPTL_ST_DONE         2
`define PPTL_ST_GEAR_ERR     3
`define PPTL_ST_FWD_OK       4
`define PPTL_ST_REV_OK       5

`define PPTL_DEFL_W          32
`define PPTL_RES_W           20
`define PPTL_RDY_CNT_W       23

`endif

//--- pptl_pkg.sv
// Types of the pulse-train position loop.
// Assumes pptl_defines.svh on the include path.
`include "pptl_defines.svh"

package pptl_pkg;

  typedef logic signed [`PPTL_DEFL_W-1:0] pptl_defl_t;
  typedef logic [`PPTL_NSYNC-1:0]         pptl_pins_t;

  typedef enum logic [1:0] {
    PPTL_SV_OFF   = 2'b00,
    PPTL_SV_WAIT  = 2'b01,
    PPTL_SV_READY = 2'b10
  } pptl_servo_t;

  typedef enum logic [`PPTL_FMT_W-1:0] {
    PPTL_FMT_TRAIN_POS = 3'b000,
    PPTL_FMT_SIGN_POS  = 3'b001,
    PPTL_FMT_QUAD_POS  = 3'b010,
    PPTL_FMT_TRAIN_NEG = 3'b011,
    PPTL_FMT_SIGN_NEG  = 3'b100,
    PPTL_FMT_QUAD_NEG  = 3'b101
  } pptl_fmt_t;

  typedef struct packed {
    pptl_pins_t s1;
    pptl_pins_t s2;
    pptl_pins_t s3;
    pptl_pins_t q;
  } pptl_sync_state_t;

  typedef struct packed {
    pptl_fmt_t                    fmt;
    logic [`PPTL_SET_W-1:0]       num;
    logic [`PPTL_SET_W-1:0]       den;
    logic [`PPTL_SET_W-1:0]       width;
    logic [`PPTL_NINT-1:0]        int_en;
    logic [`PPTL_NINT-1:0]        int_stat;
    pptl_defl_t                   defl;
    logic signed [`PPTL_RES_W-1:0] res;
    logic [1:0]                   cmd_prev;
    logic [1:0]                   enc_prev;
    logic                         clr_prev;
    pptl_servo_t                  servo;
    logic [`PPTL_RDY_CNT_W-1:0]   rdy_cnt;
    logic                         base;
    logic                         ready;
    logic                         done;
    pptl_defl_t                   speed;
    logic                         irq;
    logic                         pready;
    logic                         pslverr;
    logic [31:0]                  prdata;
  } pptl_state_t;

endpackage

//--- pptl_sync.sv
// Three-stage pin synchroniser with agreement filter for all loop inputs.
// Assumes pins are asynchronous to pclk and that ce freezes state.
`timescale 1ns/1ps
`include "pptl_defines.svh"

module pptl_sync (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               ce,
  input  wire pptl_pkg::pptl_pins_t pins,
  output pptl_pkg::pptl_pins_t    clean
);
  import pptl_pkg::*;

  pptl_sync_state_t r_reg;
  pptl_sync_state_t r_next;
  pptl_pins_t       q_next;

  genvar gi;
  generate
    for (gi = 0; gi < `PPTL_NSYNC; gi = gi + 1) begin : g_bit
      // Change accepted once stages two and three agree
      assign q_next[gi] = (r_reg.s2[gi] == r_reg.s3[gi]) ? r_reg.s3[gi] : r_reg.q[gi];
    end
  endgenerate

  always_comb begin
    r_next    = r_reg;
    r_next.s1 = pins;
    r_next.s2 = r_reg.s1;
    r_next.s3 = r_reg.s2;
    r_next.q  = q_next;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= '0;
    end else if (ce) begin
      r_reg <= r_next;
    end
  end

  assign clean = r_reg.q;
endmodule

//--- pptl_top.sv
// Position loop: command pulse decode, electronic gear, deflection counter,
// servo sequencing, completion flag, APB registers and interrupt.
// Assumes asynchronous pins and an APB master on pclk.
//
// Chosen here: the APB slave port and the register addresses.
`timescale 1ns/1ps
`include "pptl_defines.svh"

module pptl_top #(
  parameter int unsigned READY_CYC = `PPTL_READY_DELAY_US * `PPTL_CLK_MHZ
) (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    ce,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [`PPTL_ADDR_W-1:0] paddr,
  input  wire logic [31:0]             pwdata,
  output logic [31:0]                  prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic                    fwd_pulse_in,
  input  wire logic                    rev_pulse_in,
  input  wire logic                    servo_on_in,
  input  wire logic                    fwd_stroke_end_in,
  input  wire logic                    rev_stroke_end_in,
  input  wire logic                    counter_clear_in,
  input  wire logic                    enc_a_in,
  input  wire logic                    enc_b_in,
  output logic                         base_drive_en,
  output logic                         ready_out,
  output logic                         position_done_out,
  output pptl_pkg::pptl_defl_t         speed_cmd,
  output logic                         irq
);
  import pptl_pkg::*;

  localparam logic [`PPTL_RDY_CNT_W-1:0] RDY_LAST = `PPTL_RDY_CNT_W'(READY_CYC - 1);

  pptl_state_t r_reg;
  pptl_state_t r_next;
  pptl_pins_t  pins;
  pptl_pins_t  clean;

  // Quadrature step from previous and current {a,b}: +1, -1 or 0
  function automatic logic signed [1:0] quad_step(input logic [1:0] p, input logic [1:0] c);
    logic signed [1:0] s;
    s = 2'sb00;
    case ({p, c})
      4'b0010, 4'b1011, 4'b1101, 4'b0100: s = 2'sb01;
      4'b0001, 4'b0111, 4'b1110, 4'b1000: s = 2'sb11;
      default: s = 2'sb00;
    endcase
    return s;
  endfunction

  assign pins[`PPTL_IN_FWD_PULSE]  = fwd_pulse_in;
  assign pins[`PPTL_IN_REV_PULSE]  = rev_pulse_in;
  assign pins[`PPTL_IN_SERVO_ON]   = servo_on_in;
  assign pins[`PPTL_IN_FWD_STROKE] = fwd_stroke_end_in;
  assign pins[`PPTL_IN_REV_STROKE] = rev_stroke_end_in;
  assign pins[`PPTL_IN_CLEAR]      = counter_clear_in;
  assign pins[`PPTL_IN_ENC_A]      = enc_a_in;
  assign pins[`PPTL_IN_ENC_B]      = enc_b_in;

  pptl_sync u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .pins    (pins),
    .clean   (clean)
  );

  always_comb begin
    logic                          neg;
    logic                          ina;
    logic                          inb;
    logic                          fwd_ok;
    logic                          rev_ok;
    logic signed [1:0]             cstep;
    logic signed [1:0]             gstep;
    logic signed [1:0]             estep;
    logic [`PPTL_SET_W-1:0]        num_e;
    logic [`PPTL_SET_W-1:0]        den_e;
    logic                          gear_ok;
    logic signed [`PPTL_RES_W-1:0] num_s;
    logic signed [`PPTL_RES_W-1:0] den_s;
    logic signed [`PPTL_RES_W-1:0] res_t;
    pptl_defl_t                    mag;
    logic                          clr_evt;
    logic                          stroke_evt;
    logic                          acc_start;
    logic                          acc_done;
    logic [`PPTL_NINT-1:0]         int_set;
    logic [`PPTL_NINT-1:0]         int_clr;
    logic [31:0]                   rd;
    logic                          hit;
    neg        = 1'b0;
    ina        = 1'b0;
    inb        = 1'b0;
    cstep      = 2'sb00;
    gstep      = 2'sb00;
    estep      = 2'sb00;
    stroke_evt = 1'b0;
    int_clr    = '0;
    rd         = 32'h0000_0000;
    hit        = 1'b1;
    fwd_ok     = 1'b0;
    rev_ok     = 1'b0;
    num_e      = '0;
    den_e      = '0;
    gear_ok    = 1'b0;
    num_s      = '0;
    den_s      = '0;
    res_t      = '0;
    mag        = '0;
    clr_evt    = 1'b0;
    acc_start  = 1'b0;
    acc_done   = 1'b0;
    int_set    = '0;
    r_next     = r_reg;

    fwd_ok = clean[`PPTL_IN_FWD_STROKE];
    rev_ok = clean[`PPTL_IN_REV_STROKE];

    // Command format select and logic sense
    neg = (r_reg.fmt == PPTL_FMT_TRAIN_NEG) || (r_reg.fmt == PPTL_FMT_SIGN_NEG) ||
          (r_reg.fmt == PPTL_FMT_QUAD_NEG);
    ina = clean[`PPTL_IN_FWD_PULSE] ^ neg;
    inb = clean[`PPTL_IN_REV_PULSE] ^ neg;
    r_next.cmd_prev = {ina, inb};
    case (r_reg.fmt)
      PPTL_FMT_TRAIN_POS, PPTL_FMT_TRAIN_NEG: begin
        if (ina && !r_reg.cmd_prev[1] && !(inb && !r_reg.cmd_prev[0])) begin
          cstep = 2'sb01;
        end else if (inb && !r_reg.cmd_prev[0] && !(ina && !r_reg.cmd_prev[1])) begin
          cstep = 2'sb11;
        end
      end
      PPTL_FMT_SIGN_POS, PPTL_FMT_SIGN_NEG: begin
        if (ina && !r_reg.cmd_prev[1]) begin
          cstep = inb ? 2'sb11 : 2'sb01;
        end
      end
      PPTL_FMT_QUAD_POS, PPTL_FMT_QUAD_NEG: begin
        cstep = quad_step(r_reg.cmd_prev, {ina, inb});
      end
      default: cstep = 2'sb00;
    endcase

    // Pulses toward an open stroke end, or with the base blocked, are dropped
    if ((cstep == 2'sb01 && !fwd_ok) || (cstep == 2'sb11 && !rev_ok)) begin
      stroke_evt = r_reg.base;
      cstep      = 2'sb00;
    end
    if (!r_reg.base) begin
      cstep = 2'sb00;
    end

    // Electronic gear with zero treated as one and ratio check
    num_e   = (r_reg.num == '0) ? `PPTL_GEAR_DEF : r_reg.num;
    den_e   = (r_reg.den == '0) ? `PPTL_GEAR_DEF : r_reg.den;
    gear_ok = (({7'h00, num_e} * `PPTL_GEAR_MIN_DIV) >= {7'h00, den_e}) &&
              ({7'h00, num_e} <= ({7'h00, den_e} * `PPTL_GEAR_MAX_MUL));
    if (!gear_ok) begin
      num_e = `PPTL_GEAR_DEF;
      den_e = `PPTL_GEAR_DEF;
    end
    num_s = $signed({5'h00, num_e});
    den_s = $signed({5'h00, den_e});
    res_t = r_reg.res;
    if (cstep == 2'sb01) begin
      res_t = res_t + num_s;
    end else if (cstep == 2'sb11) begin
      res_t = res_t - num_s;
    end
    if (res_t >= den_s) begin
      res_t = res_t - den_s;
      gstep = 2'sb01;
    end else if (res_t <= -den_s) begin
      res_t = res_t + den_s;
      gstep = 2'sb11;
    end
    r_next.res = res_t;

    // Deflection counter: geared command in, encoder feedback out
    r_next.enc_prev = {clean[`PPTL_IN_ENC_A], clean[`PPTL_IN_ENC_B]};
    estep = quad_step(r_reg.enc_prev, r_next.enc_prev);
    r_next.defl = r_reg.defl + {{(`PPTL_DEFL_W-2){gstep[1]}}, gstep}
                             - {{(`PPTL_DEFL_W-2){estep[1]}}, estep};

    // Clear on falling edge of the clear input
    r_next.clr_prev = clean[`PPTL_IN_CLEAR];
    clr_evt = r_reg.clr_prev && !clean[`PPTL_IN_CLEAR];
    if (clr_evt || !r_reg.base) begin
      r_next.defl = '0;
      r_next.res  = '0;
    end

    // Servo sequencing
    case (r_reg.servo)
      PPTL_SV_OFF: begin
        r_next.rdy_cnt = '0;
        if (clean[`PPTL_IN_SERVO_ON]) begin
          r_next.servo = PPTL_SV_WAIT;
        end
      end
      PPTL_SV_WAIT: begin
        r_next.rdy_cnt = r_reg.rdy_cnt + 1'b1;
        if (!clean[`PPTL_IN_SERVO_ON]) begin
          r_next.servo = PPTL_SV_OFF;
        end else if (r_reg.rdy_cnt >= RDY_LAST) begin
          r_next.servo = PPTL_SV_READY;
        end
      end
      PPTL_SV_READY: begin
        if (!clean[`PPTL_IN_SERVO_ON]) begin
          r_next.servo = PPTL_SV_OFF;
        end
      end
      default: r_next.servo = PPTL_SV_OFF;
    endcase
    r_next.base  = (r_next.servo != PPTL_SV_OFF);
    r_next.ready = (r_next.servo == PPTL_SV_READY);

    // Completion and speed command
    mag = r_next.defl[`PPTL_DEFL_W-1] ? -r_next.defl : r_next.defl;
    r_next.done = r_next.base &&
                  (mag <= $signed({{(`PPTL_DEFL_W-`PPTL_SET_W){1'b0}}, r_reg.width}));
    r_next.speed = r_next.defl;
    if (!r_next.base || (!fwd_ok && r_next.defl > 0) || (!rev_ok && r_next.defl < 0)) begin
      r_next.speed = '0;
    end

    // APB: one wait state, write takes effect at the completing edge
    acc_start = psel && penable && !r_reg.pready;
    acc_done  = psel && penable && r_reg.pready;
    case (paddr)
      `PPTL_OFS_CTRL:       rd = {29'h0000_0000, r_reg.fmt};
      `PPTL_OFS_GEAR_NUM:   rd = {17'h0_0000, r_reg.num};
      `PPTL_OFS_GEAR_DEN:   rd = {17'h0_0000, r_reg.den};
      `PPTL_OFS_DONE_WIDTH: rd = {17'h0_0000, r_reg.width};
      `PPTL_OFS_STATUS:     rd = {26'h000_0000, rev_ok, fwd_ok, !gear_ok,
                                  r_reg.done, r_reg.ready, r_reg.base};
      `PPTL_OFS_DEFL:       rd = r_reg.defl;
      `PPTL_OFS_SPEED:      rd = r_reg.speed;
      `PPTL_OFS_INT_STAT:   rd = {28'h000_0000, r_reg.int_stat};
      `PPTL_OFS_INT_EN:     rd = {28'h000_0000, r_reg.int_en};
      `PPTL_OFS_INT_CLR:    rd = 32'h0000_0000;
      default:              hit = 1'b0;
    endcase
    r_next.pready = acc_start;
    if (acc_start) begin
      r_next.prdata  = pwrite ? 32'h0000_0000 : rd;
      r_next.pslverr = !hit;
    end
    if (acc_done && pwrite && hit) begin
      case (paddr)
        `PPTL_OFS_CTRL: begin
          if (pwdata[`PPTL_FMT_W-1:0] <= `PPTL_FMT_MAX) begin
            r_next.fmt = pptl_fmt_t'(pwdata[`PPTL_FMT_W-1:0]);
          end
        end
        `PPTL_OFS_GEAR_NUM:   r_next.num    = pwdata[`PPTL_SET_W-1:0];
        `PPTL_OFS_GEAR_DEN:   r_next.den    = pwdata[`PPTL_SET_W-1:0];
        `PPTL_OFS_DONE_WIDTH: r_next.width  = pwdata[`PPTL_SET_W-1:0];
        `PPTL_OFS_INT_EN:     r_next.int_en = pwdata[`PPTL_NINT-1:0];
        `PPTL_OFS_INT_CLR:    int_clr       = pwdata[`PPTL_NINT-1:0];
        default:              int_clr       = '0;
      endcase
    end

    // Sticky events; a set in the clearing cycle wins
    int_set = '0;
    int_set[`PPTL_INT_READY]  = r_next.ready && !r_reg.ready;
    int_set[`PPTL_INT_DONE]   = r_next.done && !r_reg.done;
    int_set[`PPTL_INT_CLEAR]  = clr_evt;
    int_set[`PPTL_INT_STROKE] = stroke_evt;
    r_next.int_stat = int_set | (r_reg.int_stat & ~int_clr);
    r_next.irq      = |(r_next.int_stat & r_next.int_en);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg        <= '0;
      r_reg.fmt    <= pptl_fmt_t'(`PPTL_FMT_DEF);
      r_reg.num    <= `PPTL_GEAR_DEF;
      r_reg.den    <= `PPTL_GEAR_DEF;
      r_reg.width  <= `PPTL_DONE_WIDTH_DEF;
      r_reg.servo  <= PPTL_SV_OFF;
    end else if (ce) begin
      r_reg <= r_next;
    end
  end

  assign prdata            = r_reg.prdata;
  assign pready            = r_reg.pready;
  assign pslverr           = r_reg.pslverr;
  assign base_drive_en     = r_reg.base;
  assign ready_out         = r_reg.ready;
  assign position_done_out = r_reg.done;
  assign speed_cmd         = r_reg.speed;
  assign irq               = r_reg.irq;
endmodule

//--- pptl_top_props.sv
// Checker of the position loop ports: servo sequencing, stroke blocking, clear, done.
// Assumes pptl_top with ce held high; bound below.
`timescale 1ns/1ps
module pptl_top_props #(
  parameter int unsigned READY_CYC = 20
) (
  input wire logic                 pclk,
  input wire logic                 presetn,
  input wire logic                 servo_on_in,
  input wire logic                 fwd_stroke_end_in,
  input wire logic                 rev_stroke_end_in,
  input wire logic                 counter_clear_in,
  input wire logic                 base_drive_en,
  input wire logic                 ready_out,
  input wire logic                 position_done_out,
  input wire pptl_pkg::pptl_defl_t speed_cmd
);
  import pptl_pkg::*;
  int unsigned base_cnt;

  // Cycles the base drive has been released
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      base_cnt <= 0;
    end else begin
      base_cnt <= base_drive_en ? base_cnt + 1 : 0;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_READY_DELAY: assert property ($rose(ready_out) |->
    base_cnt >= READY_CYC - 2 && base_cnt <= READY_CYC + 3) else $error("ready delay off");
  AST_READY_BOUND: assert property (
    base_drive_en && base_cnt == READY_CYC + 4 |-> ready_out) else $error("ready late");
  AST_BASE_OFF: assert property (!servo_on_in [*7] |-> !base_drive_en)
    else $error("base still on");
  AST_SPEED_OFF: assert property (!base_drive_en [*2] |-> speed_cmd == '0)
    else $error("speed with base off");
  AST_FWD_BLOCK: assert property (!fwd_stroke_end_in [*7] |-> speed_cmd <= 0)
    else $error("forward speed with stroke open");
  AST_REV_BLOCK: assert property (!rev_stroke_end_in [*7] |-> speed_cmd >= 0)
    else $error("reverse speed with stroke open");
  AST_CLEAR_FALL: assert property ($fell(counter_clear_in) |-> ##[4:8] speed_cmd == '0)
    else $error("clear not applied");
  AST_DONE_ZERO: assert property (
    (base_drive_en && fwd_stroke_end_in && rev_stroke_end_in && speed_cmd == '0) [*8]
    |-> position_done_out) else $error("done missing at zero");
endmodule

bind pptl_top pptl_top_props #(.READY_CYC(READY_CYC)) u_props (
  .pclk(pclk), .presetn(presetn), .servo_on_in(servo_on_in),
  .fwd_stroke_end_in(fwd_stroke_end_in), .rev_stroke_end_in(rev_stroke_end_in),
  .counter_clear_in(counter_clear_in), .base_drive_en(base_drive_en),
  .ready_out(ready_out), .position_done_out(position_done_out), .speed_cmd(speed_cmd));

//--- pptl_ctrl_model.sv
// Positioning controller model: command pulse trains in all six formats.
// Assumes pins are sampled on pclk; tasks are called from the bench.
`timescale 1ns/1ps
module pptl_ctrl_model (
  input  wire logic pclk,
  output logic      fwd_pulse_in,
  output logic      rev_pulse_in
);
  logic neg;

  initial begin
    fwd_pulse_in = 1'b0;
    rev_pulse_in = 1'b0;
    neg = 1'b0;
  end

  // Raw levels, inverted for negative logic, then held
  task automatic put(input logic a, input logic b, input int gap);
    @(posedge pclk);
    fwd_pulse_in <= a ^ neg;
    rev_pulse_in <= b ^ neg;
    repeat (gap - 1) @(posedge pclk);
  endtask

  task automatic idle(input logic [2:0] f);
    neg = (f > 3'h2);
    put(1'b0, 1'b0, 8);
  endtask

  // Count n a multiple of four in quadrature formats
  task automatic send(input logic [2:0] f, input logic rv, input int n);
    logic [1:0] q;
    q = 2'b00;
    for (int i = 0; i < n; i++) begin
      case (f % 3)
        0: begin
          put(!rv, rv, 8);
          put(1'b0, 1'b0, 8);
        end
        1: begin
          put(1'b0, rv, 8);
          put(1'b1, rv, 8);
          put(1'b0, rv, 8);
        end
        default: begin
          q = rv ? q - 2'd1 : q + 2'd1;
          put(q[1] ^ q[0], q[1], 250);
        end
      endcase
    end
    put(1'b0, 1'b0, 8);
  endtask
endmodule

//--- tb_pptl_top.sv
// Bench of the position loop: registers, servo, formats, gear, feedback, strokes.
// Assumes design, controller model and bound checker compiled before it.
`timescale 1ns/1ps
`include "pptl_defines.svh"
module tb_pptl_top;
  import pptl_pkg::*;
  localparam int unsigned RCYC = 20;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, re;
  logic        servo_on_in, fwd_stroke_end_in, rev_stroke_end_in, counter_clear_in;
  logic        enc_a_in, enc_b_in, fwd_pulse_in, rev_pulse_in;
  logic        base_drive_en, ready_out, position_done_out;
  logic [7:0]  paddr;
  logic [1:0]  eq;
  logic [31:0] pwdata, prdata, rq;
  pptl_defl_t  speed_cmd;
  int          err_count, check_count;

  pptl_top #(.READY_CYC(RCYC)) uut (
    .pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fwd_pulse_in(fwd_pulse_in), .rev_pulse_in(rev_pulse_in),
    .servo_on_in(servo_on_in), .fwd_stroke_end_in(fwd_stroke_end_in),
    .rev_stroke_end_in(rev_stroke_end_in), .counter_clear_in(counter_clear_in),
    .enc_a_in(enc_a_in), .enc_b_in(enc_b_in), .base_drive_en(base_drive_en),
    .ready_out(ready_out), .position_done_out(position_done_out),
    .speed_cmd(speed_cmd), .irq(irq));
  pptl_ctrl_model ctl (.pclk(pclk), .fwd_pulse_in(fwd_pulse_in), .rev_pulse_in(rev_pulse_in));

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  task automatic complete_run;
    if (err_count == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chb(input logic b, input logic e);
    chk({31'h0, b}, {31'h0, e});
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    chb(re, 1'b0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rq, e);
  endtask

  task automatic pos(input int e);
    cyc(30);
    chk(speed_cmd, 32'(e));
    rd(`PPTL_OFS_DEFL, 32'(e));
  endtask

  task automatic servo(input logic v);
    @(posedge pclk);
    servo_on_in <= v;
    for (int i = 0; i < RCYC + 40 && ready_out !== v; i++) @(posedge pclk);
    cyc(3);
    chb(ready_out, v);
    chb(base_drive_en, v);
  endtask

  task automatic enc(input int k);
    for (int i = 0; i < k; i++) begin
      eq = eq + 2'd1;
      @(posedge pclk);
      enc_a_in <= eq[1] ^ eq[0];
      enc_b_in <= eq[1];
      cyc(8);
    end
  endtask

  task automatic strokes(input logic f, input logic r);
    @(posedge pclk);
    fwd_stroke_end_in <= f;
    rev_stroke_end_in <= r;
    cyc(8);
  endtask

  initial begin
    repeat (40000) @(posedge pclk);
    err_count++;
    complete_run();
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata, eq} = '0;
    {servo_on_in, counter_clear_in, enc_a_in, enc_b_in, presetn} = '0;
    {fwd_stroke_end_in, rev_stroke_end_in} = 2'b11;
    err_count = 0;
    check_count = 0;
    cyc(20);
    presetn <= 1'b1;
    rd(`PPTL_OFS_CTRL, 32'h0);
    rd(`PPTL_OFS_GEAR_NUM, 32'h1);
    rd(`PPTL_OFS_GEAR_DEN, 32'h1);
    rd(`PPTL_OFS_DONE_WIDTH, 32'h64);
    apb(1'b0, 8'h3C, 32'h0);
    chb(re, 1'b1);
    servo(1'b1);
    for (int f = 0; f < 6; f++) begin
      servo(1'b0);
      wr(`PPTL_OFS_CTRL, 32'(f));
      ctl.idle(3'(f));
      servo(1'b1);
      ctl.send(3'(f), 1'b0, 4);
      pos(4);
      ctl.send(3'(f), 1'b1, 4);
      pos(0);
    end
    wr(`PPTL_OFS_CTRL, 32'h6);
    rd(`PPTL_OFS_CTRL, 32'h5);
    servo(1'b0);
    wr(`PPTL_OFS_CTRL, 32'h0);
    ctl.idle(3'h0);
    servo(1'b1);
    wr(`PPTL_OFS_GEAR_NUM, 32'h4);
    ctl.send(3'h0, 1'b0, 2);
    pos(8);
    wr(`PPTL_OFS_GEAR_NUM, 32'h0);
    ctl.send(3'h0, 1'b0, 1);
    pos(9);
    wr(`PPTL_OFS_GEAR_NUM, 32'h15);
    ctl.send(3'h0, 1'b0, 1);
    pos(10);
    apb(1'b0, `PPTL_OFS_STATUS, 32'h0);
    chb(rq[3], 1'b1);
    wr(`PPTL_OFS_GEAR_NUM, 32'h1);
    wr(`PPTL_OFS_GEAR_DEN, 32'h2);
    ctl.send(3'h0, 1'b0, 2);
    pos(11);
    wr(`PPTL_OFS_GEAR_DEN, 32'h0);
    ctl.send(3'h0, 1'b0, 1);
    pos(12);
    wr(`PPTL_OFS_DONE_WIDTH, 32'h2);
    enc(9);
    pos(3);
    chb(position_done_out, 1'b0);
    enc(1);
    pos(2);
    chb(position_done_out, 1'b1);
    enc(2);
    pos(0);
    wr(`PPTL_OFS_INT_CLR, 32'hF);
    wr(`PPTL_OFS_INT_EN, 32'h8);
    strokes(1'b0, 1'b1);
    ctl.send(3'h0, 1'b0, 2);
    pos(0);
    rd(`PPTL_OFS_INT_STAT, 32'h8);
    chb(irq, 1'b1);
    wr(`PPTL_OFS_INT_EN, 32'h0);
    cyc(3);
    chb(irq, 1'b0);
    wr(`PPTL_OFS_INT_CLR, 32'h8);
    rd(`PPTL_OFS_INT_STAT, 32'h0);
    rd(`PPTL_OFS_INT_CLR, 32'h0);
    ctl.send(3'h0, 1'b1, 2);
    pos(-2);
    strokes(1'b1, 1'b0);
    ctl.send(3'h0, 1'b1, 2);
    rd(`PPTL_OFS_DEFL, 32'hFFFFFFFE);
    ctl.send(3'h0, 1'b0, 2);
    pos(0);
    strokes(1'b1, 1'b1);
    ctl.send(3'h0, 1'b0, 3);
    pos(3);
    @(posedge pclk);
    counter_clear_in <= 1'b1;
    cyc(250);
    chk(speed_cmd, 32'h3);
    counter_clear_in <= 1'b0;
    pos(0);
    ctl.send(3'h0, 1'b0, 3);
    pos(3);
    servo(1'b0);
    pos(0);
    complete_run();
  end
endmodule
